// >>> verilog/ddr_cmd_pkg.sv
// Package with command codes, field positions and timing counts.
// Notes on behaviour
// - Deselect and no-op both do nothing.
// - Activate opens addressed row in bank.
// - Read starts burst at bank, column.
// - Write starts burst at bank, column.
// - Bit ten selects auto precharge, per access.
// - Burst terminate only for plain reads.
// - Precharge closes open row of bank(s).
// - Bit ten high precharges all banks.
// - Refresh: auto if enable high, else self.
// - Refresh ignores address, bank and data.
// - Bank bits pick mode or extended register.
// - Mode load stores address as opcode.
// - Masked data elements are not written.
// - Read data appears after programmed latency; rd_data_start comes two clocks after the read for every latency.
package ddr_cmd_pkg;
   // Command codes, strobes packed as {cs_n, ras_n, cas_n, we_n}.
   localparam logic [3:0] CMD_NOP   = 4'h7;
   localparam logic [3:0] CMD_ACT   = 4'h3;
   localparam logic [3:0] CMD_READ  = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_TERM  = 4'h6;
   localparam logic [3:0] CMD_PRE   = 4'h2;
   localparam logic [3:0] CMD_REF   = 4'h1;
   localparam logic [3:0] CMD_LMR   = 4'h0;
   // Address bus width and the auto precharge bit position.
   localparam int ADDR_W   = 14;
   localparam int AP_BIT   = 10;
   localparam int NBANK    = 4;
   // Mode register fields: latency code bits and their encodings.
   localparam int CL_LSB   = 4;
   localparam logic [2:0] CL_CODE_2  = 3'h2;
   localparam logic [2:0] CL_CODE_25 = 3'h6;
   // Reset values of mode and extended mode registers.
   localparam logic [13:0] MODE_RST = 14'h0000;
   localparam logic [13:0] EMODE_RST = 14'h0000;
   // Idle pin levels {cke, cs_n, ras_n, cas_n, we_n} held in reset.
   localparam logic [4:0] PIN_IDLE_CTRL = 5'h1F;
   // Latency in half clocks: 2 clocks and 2.5 clocks.
   localparam int LAT_HALF_2  = 4;
   localparam int LAT_HALF_25 = 5;
   // Command kinds reported to the array side.
   typedef enum logic [3:0] {
      OP_NONE, OP_ACT, OP_READ, OP_WRITE, OP_TERM,
      OP_PRE, OP_PRE_ALL, OP_AREF, OP_SREF, OP_LMR, OP_LEMR,
      OP_ILLEGAL
   } op_e;
endpackage

// >>> verilog/bank_tracker.sv
// One bank's open or idle state with its open row.
`timescale 1ns/100ps
module bank_tracker
   import ddr_cmd_pkg::*;
(
   input  wire logic              sys_clk,   // Module clock.
   input  wire logic              arst_n,    // Asynchronous reset, low.
   input  wire logic              open_req,  // Open a row in this bank.
   input  wire logic              close_req, // Close this bank.
   input  wire logic [ADDR_W-1:0] row_in,    // Row to open.
   output logic                   is_open,   // Bank has an open row.
   output logic [ADDR_W-1:0]      row_out    // Row currently open.
);
   logic              open_r;   // Open flag.
   logic              open_nxt; // Next open flag.
   logic [ADDR_W-1:0] row_r;    // Stored row.
   logic [ADDR_W-1:0] row_nxt;  // Next stored row.

   // Closing wins over a same-cycle open and always idles the bank; an open stores the row.
   always_comb
   begin
      open_nxt = open_r;
      row_nxt  = row_r;
      if (close_req)
      begin
         open_nxt = 1'b0;
      end
      else if (open_req)
      begin
         open_nxt = 1'b1;
         row_nxt  = row_in;
      end
   end

   // Registers the bank state.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         open_r <= 1'b0;
         row_r  <= '0;
      end
      else
      begin
         open_r <= open_nxt;
         row_r  <= row_nxt;
      end
   end

   assign is_open = open_r;
   assign row_out = row_r;
endmodule

// >>> verilog/ddr_cmd_decoder.sv
// Command decoder with bank tracking, mode registers and write masking.
`timescale 1ns/100ps
module ddr_cmd_decoder
   import ddr_cmd_pkg::*;
(
   input  wire logic              sys_clk,        // Module clock, 200 MHz.
   input  wire logic              arst_n,         // Asynchronous reset, low.
   input  wire logic              cke,            // Clock enable pin.
   input  wire logic              cs_n,           // Chip select, low.
   input  wire logic              ras_n,          // Row strobe, low.
   input  wire logic              cas_n,          // Column strobe, low.
   input  wire logic              we_n,           // Write enable, low.
   input  wire logic              bank_select_0,  // Bank address bit 0.
   input  wire logic              bank_select_1,  // Bank address bit 1.
   input  wire logic [ADDR_W-1:0] addr,           // Row, column or opcode.
   input  wire logic              wr_valid,       // Write data element valid.
   input  wire logic              write_mask,     // Mask for this element.
   input  wire logic [7:0]        wr_data,        // Write data element.
   output logic [3:0]             op_kind,        // Decoded command kind.
   output logic                   op_pulse,       // One cycle per command.
   output logic [1:0]             op_bank,        // Bank of the command.
   output logic [ADDR_W-1:0]      op_addr,        // Row or column address.
   output logic                   op_auto_pre,    // Auto precharge request.
   output logic [3:0]             bank_open,      // Open flag per bank.
   output logic                   self_refresh,   // In self refresh.
   output logic [ADDR_W-1:0]      refresh_row,    // Internal refresh row.
   output logic [ADDR_W-1:0]      mode_reg,       // Mode register value.
   output logic [ADDR_W-1:0]      ext_mode_reg,   // Extended mode value.
   output logic [2:0]             read_lat_half,  // Latency in half clocks.
   output logic                   rd_data_start,  // First read data edge.
   output logic                   wr_store,       // Store data element.
   output logic [7:0]             wr_store_data   // Data element stored.
);
   // Two-stage synchronisers for every pin input.
   localparam int PIN_W = 7 + ADDR_W + 10;
   // Reset leaves the pipeline deselected, so no command follows reset.
   localparam logic [PIN_W-1:0] PIN_RST = {PIN_IDLE_CTRL,
                                           {(PIN_W-5){1'b0}}};
   logic [PIN_W-1:0] pin_meta_r;   // First stage, read only by second.
   logic [PIN_W-1:0] pin_sync_r;   // Second stage, used by logic.
   logic             cke_s;        // Synchronised clock enable.
   logic [3:0]       cmd_s;        // Synchronised strobes.
   logic [1:0]       ba_s;         // Synchronised bank bits.
   logic [ADDR_W-1:0] addr_s;      // Synchronised address.
   logic             wv_s;         // Synchronised write valid.
   logic             wm_s;         // Synchronised write mask.
   logic [7:0]       wd_s;         // Synchronised write data.

   // Captures the pins through two flip-flops.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_meta_r <= PIN_RST;
         pin_sync_r <= PIN_RST;
      end
      else
      begin
         pin_meta_r <= {cke, cs_n, ras_n, cas_n, we_n, bank_select_1,
                        bank_select_0, addr, wr_valid, write_mask, wr_data};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign {cke_s, cmd_s, ba_s, addr_s, wv_s, wm_s, wd_s} = pin_sync_r;

   // Decoder state.
   op_e               op_r, op_nxt;            // Command kind.
   logic              pulse_r, pulse_nxt;      // Command pulse.
   logic [1:0]        bank_r, bank_nxt;        // Command bank.
   logic [ADDR_W-1:0] oaddr_r, oaddr_nxt;      // Command address.
   logic              ap_r, ap_nxt;            // Auto precharge flag.
   logic              sref_r, sref_nxt;        // Self refresh state.
   logic [ADDR_W-1:0] rrow_r, rrow_nxt;        // Refresh counter.
   logic [ADDR_W-1:0] mode_r, mode_nxt;        // Mode register.
   logic [ADDR_W-1:0] emode_r, emode_nxt;      // Extended mode register.
   logic              rd_ap_r, rd_ap_nxt;      // Last access was a write or an auto pre read.
   logic [5:0]        lat_sr_r, lat_sr_nxt;    // Read latency pipeline.
   logic              ws_r, ws_nxt;            // Write store strobe.
   logic [7:0]        wsd_r, wsd_nxt;          // Write store data.
   logic [3:0]        open_req;                // Per-bank open requests.
   logic [3:0]        close_req;               // Per-bank close requests.
   logic [3:0]        is_open;                 // Per-bank open flags.
   logic [2:0]        lat_half;                // Decoded latency.

   // Latency from the mode register; unknown codes fall back to 2.5.
   always_comb
   begin
      if (mode_r[CL_LSB +: 3] == CL_CODE_2)
         lat_half = 3'(LAT_HALF_2);
      else
         lat_half = 3'(LAT_HALF_25);
   end

   // Decodes the strobes into one command per clock.
   always_comb
   begin
      op_nxt     = OP_NONE;
      pulse_nxt  = 1'b0;
      bank_nxt   = bank_r;
      oaddr_nxt  = oaddr_r;
      ap_nxt     = 1'b0;
      sref_nxt   = sref_r;
      rrow_nxt   = rrow_r;
      mode_nxt   = mode_r;
      emode_nxt  = emode_r;
      rd_ap_nxt  = rd_ap_r;
      open_req   = '0;
      close_req  = '0;
      lat_sr_nxt = {lat_sr_r[4:0], 1'b0};
      if (sref_r)
      begin
         // Self refresh ends when clock enable returns high.
         if (cke_s)
            sref_nxt = 1'b0;
      end
      else if (cmd_s[3])
      begin
         op_nxt = OP_NONE;
      end
      else
      begin
         pulse_nxt = 1'b1;
         case (cmd_s)
            CMD_NOP:
               begin
                  op_nxt    = OP_NONE;
                  pulse_nxt = 1'b0;
               end
            CMD_ACT:
               begin
                  op_nxt    = OP_ACT;
                  bank_nxt  = ba_s;
                  oaddr_nxt = addr_s;
                  if (is_open[ba_s])
                     op_nxt = OP_ILLEGAL;
                  else
                     open_req[ba_s] = 1'b1;
               end
            CMD_READ, CMD_WRITE:
               begin
                  op_nxt    = (cmd_s == CMD_READ) ? OP_READ : OP_WRITE;
                  bank_nxt  = ba_s;
                  oaddr_nxt = addr_s;
                  ap_nxt    = addr_s[AP_BIT];
                  if (!is_open[ba_s])
                     op_nxt = OP_ILLEGAL;
                  else
                  begin
                     if (addr_s[AP_BIT])
                        close_req[ba_s] = 1'b1;
                     if (cmd_s == CMD_READ)
                     begin
                        rd_ap_nxt  = addr_s[AP_BIT];
                        lat_sr_nxt[0] = 1'b1;
                     end
                     else
                        rd_ap_nxt = 1'b1;
                  end
               end
            CMD_TERM:
               begin
                  // Only a plain read burst may be terminated.
                  op_nxt = rd_ap_r ? OP_ILLEGAL : OP_TERM;
               end
            CMD_PRE:
               begin
                  bank_nxt = ba_s;
                  if (addr_s[AP_BIT])
                  begin
                     op_nxt    = OP_PRE_ALL;
                     close_req = '1;
                  end
                  else
                  begin
                     op_nxt          = OP_PRE;
                     close_req[ba_s] = 1'b1;
                  end
               end
            CMD_REF:
               begin
                  rrow_nxt = rrow_r + 1'b1;
                  if (cke_s)
                     op_nxt = OP_AREF;
                  else
                  begin
                     op_nxt   = OP_SREF;
                     sref_nxt = 1'b1;
                  end
               end
            CMD_LMR:
               begin
                  bank_nxt = ba_s;
                  if (ba_s == 2'h0)
                  begin
                     op_nxt   = OP_LMR;
                     mode_nxt = addr_s;
                  end
                  else if (ba_s == 2'h1)
                  begin
                     op_nxt    = OP_LEMR;
                     emode_nxt = addr_s;
                  end
                  else
                     op_nxt = OP_ILLEGAL;
               end
            default:
               op_nxt = OP_ILLEGAL;
         endcase
      end
      // Write elements are stored unless their mask is high.
      ws_nxt  = wv_s & ~wm_s;
      wsd_nxt = wm_s ? wsd_r : wd_s;
   end

   // Registers the decoder state.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         op_r     <= OP_NONE;
         pulse_r  <= 1'b0;
         bank_r   <= 2'h0;
         oaddr_r  <= '0;
         ap_r     <= 1'b0;
         sref_r   <= 1'b0;
         rrow_r   <= '0;
         mode_r   <= MODE_RST;
         emode_r  <= EMODE_RST;
         rd_ap_r  <= 1'b1;
         lat_sr_r <= '0;
         ws_r     <= 1'b0;
         wsd_r    <= 8'h00;
      end
      else
      begin
         op_r     <= op_nxt;
         pulse_r  <= pulse_nxt;
         bank_r   <= bank_nxt;
         oaddr_r  <= oaddr_nxt;
         ap_r     <= ap_nxt;
         sref_r   <= sref_nxt;
         rrow_r   <= rrow_nxt;
         mode_r   <= mode_nxt;
         emode_r  <= emode_nxt;
         rd_ap_r  <= rd_ap_nxt;
         lat_sr_r <= lat_sr_nxt;
         ws_r     <= ws_nxt;
         wsd_r    <= wsd_nxt;
      end
   end

   // One tracker per bank.
   for (genvar b = 0; b < NBANK; b++)
   begin : g_bank
      bank_tracker u_bank
      (
         .sys_clk   (sys_clk),
         .arst_n    (arst_n),
         .open_req  (open_req[b]),
         .close_req (close_req[b]),
         .row_in    (addr_s),
         .is_open   (is_open[b]),
         .row_out   ()
      );
   end

   // Data start strobe two edges after the read registers (2 for both).
   assign rd_data_start = lat_sr_r[2];
   assign op_kind       = op_r;
   assign op_pulse      = pulse_r;
   assign op_bank       = bank_r;
   assign op_addr       = oaddr_r;
   assign op_auto_pre   = ap_r;
   assign bank_open     = is_open;
   assign self_refresh  = sref_r;
   assign refresh_row   = rrow_r;
   assign mode_reg      = mode_r;
   assign ext_mode_reg  = emode_r;
   assign read_lat_half = lat_half;
   assign wr_store      = ws_r;
   assign wr_store_data = wsd_r;
endmodule

// >>> tb/ddr_cmd_decoder_checker.sv
// Checker of decode timing and bank, mode and mask effects of the decoder.
`timescale 1ns/100ps
module ddr_cmd_decoder_checker
   import ddr_cmd_pkg::*;
(
   input wire logic sys_clk, arst_n, cke, cs_n, ras_n, cas_n, we_n,
   input wire logic bank_select_0, bank_select_1, wr_valid, write_mask,
   input wire logic [ADDR_W-1:0] addr, op_addr, mode_reg, ext_mode_reg,
   input wire logic [7:0] wr_data, wr_store_data,
   input wire logic [3:0] op_kind, bank_open,
   input wire logic [1:0] op_bank,
   input wire logic op_pulse, op_auto_pre, self_refresh, rd_data_start,
   input wire logic wr_store
);
   // Strobes and bank bits as they stand on the pins this cycle.
   wire logic [3:0] code = {cs_n, ras_n, cas_n, we_n};
   wire logic [1:0] bank = {bank_select_1, bank_select_0};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // A command taken with enable steady high answers three edges later.
   property p_cmd(c, q);
      cke && $past(cke) && $past(cke, 2) && !self_refresh && code == c
         |-> ##3 q;
   endproperty
   a_idle_silent: assert property ((cs_n || code == CMD_NOP)
      |-> ##3 !op_pulse) else $error("pulse after idle pins");
   a_act_opens: assert property (p_cmd(CMD_ACT, op_pulse &&
      (op_kind == OP_ILLEGAL || op_kind == OP_ACT &&
      bank_open[$past(bank, 3)] && op_addr == $past(addr, 3))))
      else $error("activate did not open bank");
   a_read_start: assert property (p_cmd(CMD_READ, op_pulse &&
      (op_kind == OP_ILLEGAL || op_kind == OP_READ && op_bank ==
      $past(bank, 3) && op_auto_pre == $past(addr[AP_BIT], 3))))
      else $error("read decode wrong");
   a_write_start: assert property (p_cmd(CMD_WRITE, op_pulse &&
      (op_kind == OP_ILLEGAL || op_kind == OP_WRITE && op_bank ==
      $past(bank, 3) && op_auto_pre == $past(addr[AP_BIT], 3))))
      else $error("write decode wrong");
   a_pre_banks: assert property (p_cmd(CMD_PRE, op_pulse &&
      ($past(addr[AP_BIT], 3) ? op_kind == OP_PRE_ALL && bank_open == 4'h0
      : op_kind == OP_PRE && !bank_open[$past(bank, 3)])))
      else $error("precharge left bank open");
   a_auto_ref: assert property (p_cmd(CMD_REF,
      op_pulse && op_kind == OP_AREF)) else $error("auto refresh missed");
   a_self_ref: assert property (code == CMD_REF && !cke && $past(cke) &&
      !self_refresh |-> ##3 op_kind == OP_SREF && self_refresh)
      else $error("self refresh entry missed");
   a_mode_load: assert property (p_cmd(CMD_LMR, op_pulse &&
      ($past(bank, 3) == 2'h0 ? op_kind == OP_LMR &&
      mode_reg == $past(addr, 3) : $past(bank, 3) == 2'h1 ?
      op_kind == OP_LEMR && ext_mode_reg == $past(addr, 3) :
      op_kind == OP_ILLEGAL))) else $error("mode load wrong");
   a_mask_store: assert property (wr_valid && !write_mask |-> ##3
      wr_store && wr_store_data == $past(wr_data, 3))
      else $error("unmasked element not stored");
   a_mask_block: assert property (!(wr_valid && !write_mask)
      |-> ##3 !wr_store) else $error("masked element stored");
   a_read_lat: assert property (op_pulse && op_kind == OP_READ
      |-> ##2 rd_data_start) else $error("read data start late");
   // Main scenarios seen at least once.
   c_act: cover property (op_pulse && op_kind == OP_ACT);
   c_rd: cover property (rd_data_start);
   c_sref: cover property (self_refresh);
   c_store: cover property (wr_store);
endmodule
bind ddr_cmd_decoder ddr_cmd_decoder_checker chk_i (.sys_clk, .arst_n,
   .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_0, .bank_select_1,
   .wr_valid, .write_mask, .addr, .op_addr, .mode_reg, .ext_mode_reg,
   .wr_data, .wr_store_data, .op_kind, .bank_open, .op_bank, .op_pulse,
   .op_auto_pre, .self_refresh, .rd_data_start, .wr_store);

// >>> tb/ddr_ctrl_model.sv
// Controller stand-in that drives command pins and write elements.
`timescale 1ns/100ps
module ddr_ctrl_model
   import ddr_cmd_pkg::*;
(
   input  wire logic         sys_clk, // Module clock.
   output logic              cke, cs_n, ras_n, cas_n, we_n, // Strobes.
   output logic              bank_select_0, bank_select_1, // Bank bits.
   output logic [ADDR_W-1:0] addr, // Address or opcode.
   output logic              wr_valid, write_mask, // Element flags.
   output logic [7:0]        wr_data // Element data.
);
   // Idle pins at time zero: deselected, enable high.
   initial
   begin
      {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
      {bank_select_1, bank_select_0, wr_valid, write_mask} = 4'h0;
      addr = '0;
      wr_data = 8'h00;
   end
   // Present one command and one data element for a single edge.
   task automatic drive(input logic [3:0] c, input logic [1:0] b,
      input logic [ADDR_W-1:0] a, input logic ke, input logic v,
      input logic m, input logic [7:0] d);
      @(posedge sys_clk);
      cke <= ke;
      {cs_n, ras_n, cas_n, we_n} <= c;
      {bank_select_1, bank_select_0} <= b;
      addr <= a;
      {wr_valid, write_mask} <= {v, m};
      wr_data <= d;
   endtask
   // Deselect; released lines flip so stale values never look held.
   task automatic idle();
      @(posedge sys_clk);
      {cs_n, wr_valid} <= 2'h2;
      {bank_select_1, bank_select_0} <= ~{bank_select_1, bank_select_0};
      addr <= ~addr;
      write_mask <= ~write_mask;
      wr_data <= ~wr_data;
   endtask
endmodule

// >>> tb/tb_ddr_cmd_decoder.sv
// Self-checking bench for the command decoder.
`timescale 1ns/100ps
module tb_ddr_cmd_decoder
   import ddr_cmd_pkg::*;
;
   logic sys_clk = 1'b0; // 200 MHz clock.
   logic arst_n = 1'b0;  // Reset, held low at start.
   wire logic cke, cs_n, ras_n, cas_n, we_n, bank_select_0, bank_select_1;
   wire logic wr_valid, write_mask, op_pulse, op_auto_pre, self_refresh;
   wire logic rd_data_start, wr_store;
   wire logic [ADDR_W-1:0] addr, op_addr, refresh_row, mode_reg;
   wire logic [ADDR_W-1:0] ext_mode_reg;
   wire logic [7:0] wr_data, wr_store_data;
   wire logic [3:0] op_kind, bank_open;
   wire logic [1:0] op_bank;
   wire logic [2:0] read_lat_half;
   int miscompares = 0; // Mismatches seen.
   int cmp_count = 0;   // Comparisons made.
   always #2.5 sys_clk = ~sys_clk;
   ddr_ctrl_model ctl (.sys_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n,
      .bank_select_0, .bank_select_1, .addr, .wr_valid, .write_mask,
      .wr_data);
   ddr_cmd_decoder dut (.sys_clk, .arst_n, .cke, .cs_n, .ras_n, .cas_n,
      .we_n, .bank_select_0, .bank_select_1, .addr, .wr_valid,
      .write_mask, .wr_data, .op_kind, .op_pulse, .op_bank, .op_addr,
      .op_auto_pre, .bank_open, .self_refresh, .refresh_row, .mode_reg,
      .ext_mode_reg, .read_lat_half, .rd_data_start, .wr_store,
      .wr_store_data);
   // Compare one value and report a mismatch.
   task automatic chk(input string n, input logic [15:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // Issue one command with enable high, then release the pins.
   task automatic one(input logic [3:0] c, input logic [1:0] b,
      input logic [ADDR_W-1:0] a);
      ctl.drive(c, b, a, 1'b1, 1'b0, 1'b0, 8'h00);
      ctl.idle();
   endtask
   // Wait a bounded time for the next pulse and check its kind.
   task automatic wait_op(input logic [3:0] k);
      int i;
      i = 0;
      do
      begin
         @(posedge sys_clk);
         #1;
         i++;
      end while (op_pulse !== 1'b1 && i < 8);
      chk("op_pulse", op_pulse, 1);
      chk("op_kind", op_kind, k);
   endtask
   // Count command pulses and stores over six cycles.
   task automatic count6(output int p, output int w);
      p = 0;
      w = 0;
      repeat (6)
      begin
         @(posedge sys_clk);
         #1;
         p += op_pulse;
         w += wr_store;
      end
   endtask
   // Deselect and no-op leave the decoder silent.
   task automatic t_idle();
      int p, w;
      count6(p, w);
      chk("reset pulses", 16'(p), 0);
      ctl.drive(CMD_NOP, 2'h3, '1, 1'b1, 1'b0, 1'b0, 8'h00);
      ctl.idle();
      count6(p, w);
      chk("idle pulses", 16'(p), 0);
   endtask
   // Mode loads to both registers, reserved banks refused.
   task automatic t_mode();
      logic [ADDR_W-1:0] a2, a25;
      a2 = ADDR_W'(CL_CODE_2) << CL_LSB;
      a25 = ADDR_W'(CL_CODE_25) << CL_LSB;
      one(CMD_LMR, 2'h0, a2);
      wait_op(OP_LMR);
      chk("mode_reg", mode_reg, a2);
      chk("lat", read_lat_half, LAT_HALF_2);
      one(CMD_LMR, 2'h1, 14'h2002);
      wait_op(OP_LEMR);
      chk("ext_mode_reg", ext_mode_reg, 14'h2002);
      for (int b = 2; b < 4; b++)
      begin
         one(CMD_LMR, 2'(b), 14'h3FFF);
         wait_op(OP_ILLEGAL);
         chk("mode kept", mode_reg, a2);
      end
      one(CMD_LMR, 2'h0, a25);
      wait_op(OP_LMR);
      chk("lat", read_lat_half, LAT_HALF_25);
      repeat (200) @(posedge sys_clk);
   endtask
   // Open, read back to back, terminate, write with auto precharge.
   task automatic t_bank();
      ctl.drive(CMD_ACT, 2'h1, 14'h1234, 1'b1, 1'b0, 1'b0, 8'h00);
      ctl.drive(CMD_READ, 2'h1, 14'h0008, 1'b1, 1'b0, 1'b0, 8'h00);
      ctl.idle();
      wait_op(OP_ACT);
      chk("bank_open", bank_open, 4'h2);
      chk("row", op_addr, 14'h1234);
      wait_op(OP_READ);
      chk("auto_pre", op_auto_pre, 0);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("rd_start", rd_data_start, 1);
      one(CMD_TERM, 2'h0, 14'h0000);
      wait_op(OP_TERM);
      one(CMD_ACT, 2'h1, 14'h0055);
      wait_op(OP_ILLEGAL);
      one(CMD_WRITE, 2'h1, 14'h0410);
      wait_op(OP_WRITE);
      chk("auto_pre", op_auto_pre, 1);
      chk("bank_open", bank_open, 4'h0);
      one(CMD_READ, 2'h1, 14'h0000);
      wait_op(OP_ILLEGAL);
   endtask
   // Single-bank and all-bank precharge.
   task automatic t_pre();
      for (int b = 0; b < 4; b += (b == 0) ? 2 : 1)
      begin
         one(CMD_ACT, 2'(b), 14'h0100);
         wait_op(OP_ACT);
      end
      one(CMD_PRE, 2'h2, 14'h0000);
      wait_op(OP_PRE);
      chk("bank_open", bank_open, 4'h9);
      one(CMD_PRE, 2'h0, 14'h0400);
      wait_op(OP_PRE_ALL);
      chk("bank_open", bank_open, 4'h0);
   endtask
   // Auto refresh, then self refresh entry, ignored command and exit.
   task automatic t_refresh();
      logic [ADDR_W-1:0] r;
      int p, w;
      r = refresh_row;
      one(CMD_REF, 2'h2, 14'h2AAA);
      wait_op(OP_AREF);
      ctl.drive(CMD_REF, 2'h0, 14'h0000, 1'b0, 1'b0, 1'b0, 8'h00);
      ctl.idle();
      wait_op(OP_SREF);
      chk("self_refresh", self_refresh, 1);
      chk("refresh_row", refresh_row, r + 14'h2);
      ctl.drive(CMD_ACT, 2'h0, 14'h0000, 1'b0, 1'b0, 1'b0, 8'h00);
      ctl.idle();
      count6(p, w);
      chk("sref pulses", 16'(p), 0);
      ctl.drive(CMD_NOP, 2'h0, 14'h0000, 1'b1, 1'b0, 1'b0, 8'h00);
      ctl.idle();
      count6(p, w);
      chk("self_refresh", self_refresh, 0);
   endtask
   // Unmasked element stored, masked one inhibited.
   task automatic t_mask();
      int p, w;
      ctl.drive(CMD_NOP, 2'h0, 14'h0000, 1'b1, 1'b1, 1'b0, 8'hA5);
      ctl.drive(CMD_NOP, 2'h0, 14'h0000, 1'b1, 1'b1, 1'b1, 8'h3C);
      ctl.idle();
      repeat (1) @(posedge sys_clk);
      #1;
      chk("wr_store", wr_store, 1);
      chk("wr_data", wr_store_data, 8'hA5);
      count6(p, w);
      chk("masked stores", 16'(w), 0);
   endtask
   // Print the counts and the verdict, then stop.
   task automatic print_verdict();
      $display("compares %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence after reset.
   initial
   begin
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_idle();
      t_mode();
      t_bank();
      t_pre();
      t_refresh();
      t_mask();
      print_verdict();
   end
   // Watchdog against a hang.
   initial
   begin
      #20000;
      miscompares++;
      print_verdict();
   end
endmodule
